// [rtl/frs_pkg.sv]
// Shared constants, types and register map of the broadcast data receiver.
package frs_pkg;

   // ---------------------------------------------------------------------
   // Block coding
   // ---------------------------------------------------------------------
   localparam int BLK_W = 26;
   localparam int DATA_W = 16;
   localparam int CHK_W = 10;
   localparam logic [10:0] GEN_POLY = 11'h5B9;
   localparam logic [4:0] BLK_LAST_BIT = 5'h19;
   localparam int FIFO_DEPTH = 126;

   typedef enum logic [2:0] {
      OFS_A = 3'h0,
      OFS_B = 3'h1,
      OFS_C = 3'h2,
      OFS_CP = 3'h3,
      OFS_D = 3'h4,
      OFS_E = 3'h5
   } frs_ofs_t;

   localparam logic [9:0] OFS_WORD_A = 10'h0FC;
   localparam logic [9:0] OFS_WORD_B = 10'h198;
   localparam logic [9:0] OFS_WORD_C = 10'h168;
   localparam logic [9:0] OFS_WORD_CP = 10'h350;
   localparam logic [9:0] OFS_WORD_D = 10'h1B4;
   localparam logic [9:0] OFS_WORD_E = 10'h000;

   // Offset word added to the check bits of each block kind.
   function automatic logic [9:0] ofs_word(input frs_ofs_t o);
      case (o)
         OFS_A: ofs_word = OFS_WORD_A;
         OFS_B: ofs_word = OFS_WORD_B;
         OFS_C: ofs_word = OFS_WORD_C;
         OFS_CP: ofs_word = OFS_WORD_CP;
         OFS_D: ofs_word = OFS_WORD_D;
         default: ofs_word = OFS_WORD_E;
      endcase
   endfunction

   // Sync states, Gray coded along search, pre-sync, lock.
   typedef enum logic [1:0] {
      SY_SRCH = 2'h0,
      SY_PRE = 2'h1,
      SY_LOCK = 2'h3
   } frs_sync_t;

   // One decoded block as buffered for software.
   typedef struct packed {
      logic [15:0] data;
      frs_ofs_t kind;
      logic fixed;
   } frs_blk_t;

   // ---------------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SYNC = 8'h04;
   localparam logic [7:0] ADDR_BMATCH = 8'h08;
   localparam logic [7:0] ADDR_PI = 8'h0C;
   localparam logic [7:0] ADDR_PTHR = 8'h10;
   localparam logic [7:0] ADDR_PDUR = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_DATA = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h24;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h28;

   localparam int CTRL_EN = 0;
   localparam int CTRL_EFILT = 1;
   localparam int CTRL_PI_EN = 2;
   localparam int CTRL_BM_EN = 3;
   localparam int SYNC_ACQ_LSB = 0;
   localparam int SYNC_LOSS_LSB = 8;
   localparam int SYNC_MAINT_LSB = 16;
   localparam int BM_PAT_LSB = 0;
   localparam int BM_MASK_LSB = 16;
   localparam int PDUR_QUIET_LSB = 0;
   localparam int PDUR_LOUD_LSB = 16;
   localparam logic [3:0] ACQ_MIN = 4'h2;

   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] SYNC_RST = 32'h0002_0402;
   localparam logic [31:0] BMATCH_RST = 32'hFFFF_0000;
   localparam logic [31:0] PI_RST = 32'h0000_0000;
   localparam logic [31:0] PTHR_RST = 32'h0000_0100;
   localparam logic [31:0] PDUR_RST = 32'h0010_0400;

   // Interrupt bit positions.
   localparam int IRQ_W = 7;
   localparam int IRQ_BFULL = 0;
   localparam int IRQ_BPART = 1;
   localparam int IRQ_PI = 2;
   localparam int IRQ_PAUSE = 3;
   localparam int IRQ_ACQ = 4;
   localparam int IRQ_LOST = 5;
   localparam int IRQ_OVF = 6;

   // Whole state of the receiver top.
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] sync_cfg;
      logic [31:0] bmatch;
      logic [31:0] pi;
      logic [31:0] pthr;
      logic [31:0] pdur;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_en;
      logic ack;
      logic [31:0] rdat;
      logic [BLK_W-1:0] win;
      logic [4:0] bitc;
      frs_sync_t sy;
      frs_ofs_t want;
      logic [3:0] good_cnt;
      logic [3:0] bad_cnt;
      logic [3:0] run_cnt;
      logic [15:0] quiet_cnt;
      logic [15:0] loud_cnt;
      logic silent;
   } frs_st_t;

endpackage

// [rtl/frs_blk_dec.sv]
// Block syndrome check and single-bit error correction.
`timescale 1ns/100ps
module frs_blk_dec (
   input wire logic [25:0] word,
   input wire frs_pkg::frs_ofs_t want,
   input wire logic allow_fix,
   output logic [5:0] hit,
   output logic ok,
   output logic fixed,
   output frs_pkg::frs_ofs_t kind,
   output logic [15:0] data
);

   // ---------------------------------------------------------------------
   // Remainder of a 26-bit word by the generator polynomial
   // ---------------------------------------------------------------------
   function automatic logic [9:0] rem26(input logic [25:0] w);
      logic [10:0] r;
      r = 11'h000;
      for (int i = frs_pkg::BLK_W - 1; i >= 0; i--) begin
         r = {r[9:0], w[i]};
         if (r[10]) begin
            r = r ^ frs_pkg::GEN_POLY;
         end
      end
      return r[9:0];
   endfunction

   logic [9:0] syn;
   logic [9:0] err;
   logic [25:0] cw;

   // Exact syndrome hits, then a correction attempt for the wanted kind.
   always_comb begin
      syn = rem26(word);
      for (int k = 0; k < 6; k++) begin
         hit[k] = (syn == frs_pkg::ofs_word(frs_pkg::frs_ofs_t'(k)));
      end
      kind = want;
      if (want == frs_pkg::OFS_C && hit[frs_pkg::OFS_CP]) begin
         kind = frs_pkg::OFS_CP;
      end
      err = syn ^ frs_pkg::ofs_word(kind);
      cw = word;
      fixed = 1'b0;
      if (err != 10'h000 && allow_fix) begin
         for (int i = 0; i < frs_pkg::BLK_W; i++) begin
            if (rem26(26'h1 << i) == err) begin
               cw[i] = ~word[i];
               fixed = 1'b1;
            end
         end
      end
      ok = (err == 10'h000) || fixed;
      data = cw[25:10];
   end

endmodule

// [rtl/frs_fifo.sv]
// Block buffer between the decoder and the software read port.
`timescale 1ns/100ps
module frs_fifo #(
   parameter int W = 21,
   parameter int DEPTH = 126
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [6:0] level
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } frs_fifo_st_t;

   frs_fifo_st_t r;
   frs_fifo_st_t n;
   logic [W-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Honest full and empty from the fill count.
   assign in_ready = (r.cnt != CW'(DEPTH));
   assign out_valid = (r.cnt != '0);
   assign out_data = mem[r.rp];
   assign level = 7'(r.cnt);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer and count update.
   always_comb begin
      n = r;
      if (push) begin
         n.wp = (r.wp == PTR_LAST) ? '0 : r.wp + PW'(1);
      end
      if (pop) begin
         n.rp = (r.rp == PTR_LAST) ? '0 : r.rp + PW'(1);
      end
      if (push && !pop) begin
         n.cnt = r.cnt + CW'(1);
      end else if (pop && !push) begin
         n.cnt = r.cnt - CW'(1);
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Storage array, holding up to DEPTH blocks.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[r.wp] <= in_data;
      end
   end

endmodule

// [rtl/frs_rx_top.sv]
// Broadcast data receiver: sync, block buffer, match and pause detection.
`timescale 1ns/100ps
// Notes on behaviour
// - The bit stream is cut into 26-bit blocks, each checked, and corrected only while sync is locked, and sync follows the blocks.
// - Sync is declared after a programmable run of error-free blocks in sequence, at least two.
// - Acquisition, maintenance and loss of sync all use counts that software programs.
// - Decoded blocks wait in a buffer of 126 entries until software reads them.
// - Each B block is compared with a programmed pattern and a full or partial match raises an interrupt.
// - An A or C' block carrying the programmed identification code raises an interrupt.
// - Audio below a programmed level for a programmed number of samples raises an interrupt.
// - Entering and leaving silence each need a run of consecutive samples of its own programmed length, a single one if that length is 0 or 1.
// - Software takes the buffered blocks through the data register of the host port.
module frs_rx_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_bit,
   input wire logic rx_bit_vld,
   input wire logic [15:0] aud_smp,
   input wire logic aud_vld,
   output logic irq,
   output logic synced
);

   // ---------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------

   // Byte-lane write merge.
   function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] sel);
      logic [31:0] v;
      v = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            v[8*b +: 8] = d[8*b +: 8];
         end
      end
      return v;
   endfunction

   // Kind expected after a given block kind.
   function automatic frs_pkg::frs_ofs_t next_kind(input frs_pkg::frs_ofs_t k);
      case (k)
         frs_pkg::OFS_A: next_kind = frs_pkg::OFS_B;
         frs_pkg::OFS_B: next_kind = frs_pkg::OFS_C;
         frs_pkg::OFS_C: next_kind = frs_pkg::OFS_D;
         frs_pkg::OFS_CP: next_kind = frs_pkg::OFS_D;
         default: next_kind = frs_pkg::OFS_A;
      endcase
   endfunction

   // Saturating 4-bit increment.
   function automatic logic [3:0] inc4(input logic [3:0] v);
      return (v == 4'hF) ? 4'hF : v + 4'h1;
   endfunction

   frs_pkg::frs_st_t r;
   frs_pkg::frs_st_t n;

   logic req;
   logic wr;
   logic rd_data;
   logic [25:0] win_nxt;
   logic [5:0] hit;
   logic dec_ok;
   logic dec_fix;
   frs_pkg::frs_ofs_t dec_kind;
   logic [15:0] dec_data;
   frs_pkg::frs_blk_t blk_in;
   frs_pkg::frs_blk_t blk_out;
   logic store;
   logic fifo_rdy;
   logic fifo_vld;
   logic [6:0] fifo_lvl;
   logic [frs_pkg::IRQ_W-1:0] ev;
   logic [frs_pkg::IRQ_W-1:0] clr;
   logic [3:0] acq_need;
   logic [3:0] loss_bad;
   logic [3:0] maint_good;
   logic [15:0] bm_mask;
   logic [16:0] mag;
   logic below;

   // ---------------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------------

   frs_blk_dec u_dec (
      .word(win_nxt),
      .want(r.want),
      .allow_fix(r.sy == frs_pkg::SY_LOCK),
      .hit(hit),
      .ok(dec_ok),
      .fixed(dec_fix),
      .kind(dec_kind),
      .data(dec_data)
   );

   frs_fifo #(
      .W($bits(frs_pkg::frs_blk_t)),
      .DEPTH(frs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(store),
      .in_ready(fifo_rdy),
      .in_data(blk_in),
      .out_valid(fifo_vld),
      .out_ready(rd_data),
      .out_data(blk_out),
      .level(fifo_lvl)
   );

   // ---------------------------------------------------------------------
   // Bus decode and outputs
   // ---------------------------------------------------------------------

   // Requests are answered one cycle later; the data register pops on read.
   assign req = wb_cyc_i && wb_stb_i && !r.ack;
   assign wr = req && wb_we_i;
   assign rd_data = req && !wb_we_i && (wb_adr_i == frs_pkg::ADDR_DATA);
   assign clr = (wr && wb_adr_i == frs_pkg::ADDR_IRQ_CLR) ?
                wb_dat_i[frs_pkg::IRQ_W-1:0] : '0;
   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.rdat;
   assign irq = |(r.irq_st & r.irq_en);
   assign synced = (r.sy == frs_pkg::SY_LOCK);

   // Programmed parameters, with the acquisition run clamped to two.
   assign acq_need = (r.sync_cfg[frs_pkg::SYNC_ACQ_LSB +: 4] < frs_pkg::ACQ_MIN) ?
                     frs_pkg::ACQ_MIN : r.sync_cfg[frs_pkg::SYNC_ACQ_LSB +: 4];
   assign loss_bad = r.sync_cfg[frs_pkg::SYNC_LOSS_LSB +: 4];
   assign maint_good = r.sync_cfg[frs_pkg::SYNC_MAINT_LSB +: 4];
   assign bm_mask = r.bmatch[frs_pkg::BM_MASK_LSB +: 16];
   assign win_nxt = {r.win[24:0], rx_bit};

   // Audio magnitude against the pause threshold.
   assign mag = aud_smp[15] ? 17'(-{aud_smp[15], aud_smp}) :
                {1'b0, aud_smp};
   assign below = (mag < {1'b0, r.pthr[15:0]});

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   always_comb begin
      n = r;
      ev = '0;
      store = 1'b0;
      blk_in = '{data: dec_data, kind: dec_kind, fixed: dec_fix};
      n.ack = req;

      // Register writes and read data capture.
      if (wr) begin
         unique case (wb_adr_i)
            frs_pkg::ADDR_CTRL: n.ctrl = wb_merge(r.ctrl, wb_dat_i, wb_sel_i);
            frs_pkg::ADDR_SYNC:
               n.sync_cfg = wb_merge(r.sync_cfg, wb_dat_i, wb_sel_i);
            frs_pkg::ADDR_BMATCH:
               n.bmatch = wb_merge(r.bmatch, wb_dat_i, wb_sel_i);
            frs_pkg::ADDR_PI: n.pi = wb_merge(r.pi, wb_dat_i, wb_sel_i);
            frs_pkg::ADDR_PTHR: n.pthr = wb_merge(r.pthr, wb_dat_i, wb_sel_i);
            frs_pkg::ADDR_PDUR: n.pdur = wb_merge(r.pdur, wb_dat_i, wb_sel_i);
            frs_pkg::ADDR_IRQ_EN:
               n.irq_en = wb_dat_i[frs_pkg::IRQ_W-1:0];
            default: n.ack = req;
         endcase
      end
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            frs_pkg::ADDR_CTRL: n.rdat = r.ctrl;
            frs_pkg::ADDR_SYNC: n.rdat = r.sync_cfg;
            frs_pkg::ADDR_BMATCH: n.rdat = r.bmatch;
            frs_pkg::ADDR_PI: n.rdat = r.pi;
            frs_pkg::ADDR_PTHR: n.rdat = r.pthr;
            frs_pkg::ADDR_PDUR: n.rdat = r.pdur;
            frs_pkg::ADDR_STATUS:
               n.rdat = {17'h00000, fifo_lvl, 4'h0, !fifo_rdy, !fifo_vld,
                         r.silent, synced};
            frs_pkg::ADDR_DATA:
               n.rdat = fifo_vld ? {11'h000, 1'b1, blk_out} : 32'h0000_0000;
            frs_pkg::ADDR_IRQ_ST: n.rdat = {25'h0000000, r.irq_st};
            frs_pkg::ADDR_IRQ_EN: n.rdat = {25'h0000000, r.irq_en};
            default: n.rdat = 32'h0000_0000;
         endcase
      end

      // Block framing and flywheel sync, one step per received bit.
      if (rx_bit_vld && r.ctrl[frs_pkg::CTRL_EN]) begin
         n.win = win_nxt;
         n.bitc = r.bitc + 5'h01;
         unique case (r.sy)
            frs_pkg::SY_SRCH: begin
               for (int k = frs_pkg::OFS_D; k >= 0; k--) begin
                  if (hit[k]) begin
                     n.want = next_kind(frs_pkg::frs_ofs_t'(k));
                     n.bitc = 5'h00;
                     n.good_cnt = 4'h1;
                     n.sy = frs_pkg::SY_PRE;
                  end
               end
            end
            frs_pkg::SY_PRE: begin
               if (r.bitc == frs_pkg::BLK_LAST_BIT) begin
                  n.bitc = 5'h00;
                  n.want = next_kind(r.want);
                  if (dec_ok) begin
                     n.good_cnt = inc4(r.good_cnt);
                     if (inc4(r.good_cnt) >= acq_need) begin
                        n.sy = frs_pkg::SY_LOCK;
                        n.bad_cnt = 4'h0;
                        n.run_cnt = 4'h0;
                        ev[frs_pkg::IRQ_ACQ] = 1'b1;
                     end
                  end else begin
                     n.sy = frs_pkg::SY_SRCH;
                  end
               end
            end
            frs_pkg::SY_LOCK: begin
               if (r.bitc == frs_pkg::BLK_LAST_BIT) begin
                  n.bitc = 5'h00;
                  n.want = next_kind(r.want);
                  if (dec_ok) begin
                     store = 1'b1;
                     n.run_cnt = inc4(r.run_cnt);
                     if (inc4(r.run_cnt) >= maint_good) begin
                        n.bad_cnt = 4'h0;
                     end
                     if (r.ctrl[frs_pkg::CTRL_BM_EN] &&
                         dec_kind == frs_pkg::OFS_B &&
                         ((dec_data ^ r.bmatch[frs_pkg::BM_PAT_LSB +: 16]) &
                          bm_mask) == 16'h0000) begin
                        if (&bm_mask) begin
                           ev[frs_pkg::IRQ_BFULL] = 1'b1;
                        end else begin
                           ev[frs_pkg::IRQ_BPART] = 1'b1;
                        end
                     end
                     if (r.ctrl[frs_pkg::CTRL_PI_EN] &&
                         (dec_kind == frs_pkg::OFS_A ||
                          dec_kind == frs_pkg::OFS_CP) &&
                         dec_data == r.pi[15:0]) begin
                        ev[frs_pkg::IRQ_PI] = 1'b1;
                     end
                  end else if (hit[frs_pkg::OFS_E]) begin
                     blk_in.kind = frs_pkg::OFS_E;
                     blk_in.fixed = 1'b0;
                     blk_in.data = win_nxt[25:10];
                     store = !r.ctrl[frs_pkg::CTRL_EFILT];
                  end else begin
                     n.run_cnt = 4'h0;
                     n.bad_cnt = inc4(r.bad_cnt);
                     if (inc4(r.bad_cnt) >= loss_bad) begin
                        n.sy = frs_pkg::SY_SRCH;
                        ev[frs_pkg::IRQ_LOST] = 1'b1;
                     end
                  end
               end
            end
         endcase
      end
      ev[frs_pkg::IRQ_OVF] = store && !fifo_rdy;

      // Pause detection with separate entry and exit runs.
      if (aud_vld) begin
         if (!r.silent) begin
            n.loud_cnt = 16'h0000;
            if (!below) begin
               n.quiet_cnt = 16'h0000;
            end else if (r.quiet_cnt + 16'h0001 >=
                         r.pdur[frs_pkg::PDUR_QUIET_LSB +: 16]) begin
               n.silent = 1'b1;
               n.quiet_cnt = 16'h0000;
               ev[frs_pkg::IRQ_PAUSE] = 1'b1;
            end else begin
               n.quiet_cnt = r.quiet_cnt + 16'h0001;
            end
         end else begin
            n.quiet_cnt = 16'h0000;
            if (below) begin
               n.loud_cnt = 16'h0000;
            end else if (r.loud_cnt + 16'h0001 >=
                         r.pdur[frs_pkg::PDUR_LOUD_LSB +: 16]) begin
               n.silent = 1'b0;
               n.loud_cnt = 16'h0000;
            end else begin
               n.loud_cnt = r.loud_cnt + 16'h0001;
            end
         end
      end

      // Sticky status: a new event wins over a clear in the same cycle.
      n.irq_st = (r.irq_st & ~clr) | ev;
   end

   // ---------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
         r.ctrl <= frs_pkg::CTRL_RST;
         r.sync_cfg <= frs_pkg::SYNC_RST;
         r.bmatch <= frs_pkg::BMATCH_RST;
         r.pi <= frs_pkg::PI_RST;
         r.pthr <= frs_pkg::PTHR_RST;
         r.pdur <= frs_pkg::PDUR_RST;
         r.sy <= frs_pkg::SY_SRCH;
         r.want <= frs_pkg::OFS_A;
      end else begin
         r <= n;
      end
   end

endmodule

// [dv/frs_rx_chk.sv]
// Port-level assertions of the broadcast data receiver top.
`timescale 1ns/100ps
module frs_rx_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rx_bit_vld,
   input wire logic aud_vld,
   input wire logic irq,
   input wire logic synced
);
   // ------------------------------------------------------------------
   // Bus, sync and interrupt relations
   // ------------------------------------------------------------------
   // All checks run on the one clock and stand still during reset.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   a_ack_next:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after a request");
   a_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_cause:
      assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   a_unmapped_zero:
      assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
         wb_adr_i == 8'h3C |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_out_of_reset:
      assert property ($fell(srst) |-> !synced && !irq && !wb_ack_o)
      else $error("outputs not quiet after reset");
   a_sync_on_bit:
      assert property ($rose(synced) |-> $past(rx_bit_vld))
      else $error("sync gained without a bit");
   a_sync_kept:
      assert property (synced && !rx_bit_vld && !(wb_cyc_i && wb_stb_i)
         |=> synced)
      else $error("sync lost without a cause");
   a_irq_cause:
      assert property ($rose(irq) |-> $past(rx_bit_vld || aud_vld ||
         (wb_cyc_i && wb_stb_i && wb_we_i)))
      else $error("interrupt rose without an event");
endmodule
bind frs_rx_top frs_rx_chk u_chk (.clk(clk), .srst(srst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .rx_bit_vld(rx_bit_vld), .aud_vld(aud_vld), .irq(irq),
   .synced(synced));

// [dv/frs_host.sv]
// Software side model: classic bus master cycles on the register port.
`timescale 1ns/100ps
module frs_host (
   input wire logic clk,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [7:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   input wire logic [31:0] rdat,
   input wire logic ack
);
   // ------------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------------
   // The bus is idle until the first request.
   initial begin
      {cyc, stb, we, adr, sel, dat} = '0;
   end
   // One cycle, held until ack is seen at a rising edge.
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
endmodule

// [dv/frs_rx_tb_top.sv]
// Self-checking bench of the broadcast data receiver.
`timescale 1ns/100ps
module frs_rx_tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cyc, stb, we, ack, irq, synced, rx_bit, rx_bit_vld, aud_vld;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   logic [15:0] aud_smp, p;
   logic [20:0] exp_q[$];
   int num_errors = 0;
   int checked = 0;
   localparam logic [9:0] OW [5] = '{frs_pkg::OFS_WORD_A,
      frs_pkg::OFS_WORD_B, frs_pkg::OFS_WORD_C, frs_pkg::OFS_WORD_CP,
      frs_pkg::OFS_WORD_D};
   // ------------------------------------------------------------------
   // Clock, design and host model
   // ------------------------------------------------------------------
   // Free running 100 MHz clock.
   always #5 clk = ~clk;
   frs_rx_top DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rx_bit(rx_bit),
      .rx_bit_vld(rx_bit_vld), .aud_smp(aud_smp), .aud_vld(aud_vld),
      .irq(irq), .synced(synced));
   frs_host u_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .sel(sel), .dat(wdat), .rdat(rdat), .ack(ack));
   task automatic cmp(input string n, input logic [31:0] e,
         input logic [31:0] s);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input string n, input logic [7:0] a,
         input logic [31:0] e);
      u_host.xfer(1'b0, a, 32'h0, q);
      cmp(n, e, q);
   endtask
   // Check word of a block before the offset is added.
   function automatic logic [9:0] crc(input logic [15:0] d);
      logic [25:0] r;
      r = {d, 10'h000};
      for (int i = 25; i >= 10; i--) begin
         if (r[i]) r[i-:11] = r[i-:11] ^ frs_pkg::GEN_POLY;
      end
      return r[9:0];
   endfunction
   // Sends one block msb first, optionally with one bit flipped.
   task automatic blk(input logic [2:0] k, input logic [15:0] d,
         input int f, input bit s);
      logic [25:0] w;
      w = {d, crc(d) ^ OW[k]};
      if (f < 26) w[f] = ~w[f];
      if (s) exp_q.push_back({1'b1, d, k, f < 26});
      for (int i = 25; i >= 0; i--) begin
         @(posedge clk);
         rx_bit <= w[i];
         rx_bit_vld <= 1'b1;
      end
      @(posedge clk);
      rx_bit_vld <= 1'b0;
      rx_bit <= ~w[0];
      #1;
   endtask
   task automatic smp(input logic [15:0] v);
      @(posedge clk);
      aud_smp <= v;
      aud_vld <= 1'b1;
      @(posedge clk);
      aud_vld <= 1'b0;
      #1;
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   // Main sequence: reset values, sync, buffer, interrupts, pause.
   initial begin
      {rx_bit, rx_bit_vld, aud_vld, aud_smp} = '0;
      void'($urandom(70123));
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rc("sync", frs_pkg::ADDR_SYNC, frs_pkg::SYNC_RST);
      rc("bmatch", frs_pkg::ADDR_BMATCH, frs_pkg::BMATCH_RST);
      rc("unmapped", 8'h3C, 32'h0);
      p = 16'($urandom);
      wr(frs_pkg::ADDR_CTRL, 32'h0000_000D);
      wr(frs_pkg::ADDR_PI, {16'h0000, p});
      wr(frs_pkg::ADDR_IRQ_EN, 32'h0000_007F);
      // Zero data cannot alias a syndrome while the window fills.
      blk(3'h0, 16'h0000, 26, 0);
      blk(3'h1, 16'h8001, 26, 0);
      cmp("synced", 32'h1, {31'h0, synced});
      for (int k = 0; k < 8; k++) begin
         if (k == 4) wr(frs_pkg::ADDR_BMATCH, 32'h00FF_0012);
         case (k % 4)
            0: blk(3'h2, 16'($urandom), 26, 1);
            1: blk(3'h4, 16'($urandom),
                  k == 1 ? int'($urandom_range(25, 0)) : 26, 1);
            2: blk(3'h0, p, 26, 1);
            default: blk(3'h1, k == 3 ? 16'h0000 : 16'hA512, 26, 1);
         endcase
      end
      cmp("irq", 32'h1, {31'h0, irq});
      rc("irq_st", frs_pkg::ADDR_IRQ_ST, 32'h0000_0017);
      rc("status", frs_pkg::ADDR_STATUS, 32'h0000_0801);
      while (exp_q.size() > 0)
         rc("data", frs_pkg::ADDR_DATA, {11'h0, exp_q.pop_front()});
      rc("empty", frs_pkg::ADDR_DATA, 32'h0);
      wr(frs_pkg::ADDR_IRQ_EN, 32'h0);
      cmp("irq masked", 32'h0, {31'h0, irq});
      wr(frs_pkg::ADDR_IRQ_CLR, 32'h0000_007F);
      rc("irq cleared", frs_pkg::ADDR_IRQ_ST, 32'h0);
      wr(frs_pkg::ADDR_PDUR, 32'h0002_0003);
      wr(frs_pkg::ADDR_IRQ_EN, 32'h0000_0008);
      smp(16'($urandom_range(255, 0)));
      smp(16'hFF01);
      smp(16'h0100);
      smp(16'($urandom_range(255, 0)));
      smp(16'hFF01);
      cmp("early pause", 32'h0, {31'h0, irq});
      smp(16'h0000);
      cmp("pause irq", 32'h1, {31'h0, irq});
      rc("silent", frs_pkg::ADDR_STATUS, 32'h0000_0007);
      smp(16'h8000);
      smp(16'h8000);
      rc("loud", frs_pkg::ADDR_STATUS, 32'h0000_0005);
      test_done;
   end
   // Watchdog against a hung handshake.
   initial begin
      #300000;
      num_errors++;
      $display("watchdog expired");
      test_done;
   end
endmodule
